// File: devcap_regs.sv
// Purpose: Device capability and device control registers on AHB-Lite
// Assumes: Single-word transfers; zero wait states; OKAY response always
// Notes: Extra load register takes management or nonvolatile-memory defaults
`timescale 1ns/100ps
module pcie_device_cap_ctrl_regs
	import devcap_pkg::*;
#(
	parameter logic UPSTREAM = 1'b1
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        por_n,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire slot_power_s slot_power,
	input  wire cap_load_s   cap_load,
	output logic [3:0]       err_report_en,
	output logic [2:0]       max_payload,
	output logic             aux_power_en
);
	logic        wr_pend_r;
	logic [7:0]  wr_addr_r;
	logic [2:0]  mps_cap_r;
	logic        rber_r;
	logic [7:0]  splv_r;
	logic [1:0]  spls_r;
	logic [3:0]  err_en_r;
	logic [2:0]  mps_r;
	logic        aux_q;
	logic [31:0] hrdata_r;
	logic        aux_out_r;

	function automatic logic [2:0] clamp_mps(input logic [2:0] req, input logic [2:0] cap);
		clamp_mps = (req > cap) ? cap : req;
	endfunction : clamp_mps

	wire         take     = hsel && hready && htrans[1];
	// Capability word is read-only: writes to it decode to nothing
	wire         wr_ctrl  = wr_pend_r && (wr_addr_r == CTRL_OFFSET);
	wire         wr_load  = wr_pend_r && (wr_addr_r == LOAD_OFFSET);
	wire [2:0]   mps_req  = hwdata[CTRL_MPS_LSB +: 3];
	// Reserved and hardwired fields stay zero; latencies fixed 000b
	wire [31:0]  cap_word = {4'h0, spls_r, splv_r, 2'h0, rber_r, 3'h0,
				6'h00, 3'h0, mps_cap_r};
	wire [31:0]  ctrl_word = {16'h0000, 5'h00, aux_q, 2'h0, mps_r, 1'b0,
				err_en_r};
	wire [31:0]  load_word = {28'h0, rber_r, mps_cap_r};
	wire [31:0]  rd_mux = (haddr == CAP_OFFSET)  ? cap_word :
			      (haddr == CTRL_OFFSET) ? ctrl_word :
			      (haddr == LOAD_OFFSET) ? load_word : 32'h0;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata_r  <= 32'h0;
		end else begin
			wr_pend_r <= take && hwrite;
			wr_addr_r <= haddr;
			if (take && !hwrite) begin
				hrdata_r <= rd_mux;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mps_cap_r <= MPS_CAP_RESET;
			rber_r    <= RBER_RESET;
		end else if (cap_load.valid) begin
			mps_cap_r <= cap_load.mps;
			rber_r    <= cap_load.rber;
		end else if (wr_load) begin
			mps_cap_r <= hwdata[2:0];
			rber_r    <= hwdata[LOAD_RBER_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			splv_r <= 8'h00;
			spls_r <= 2'h0;
		end else if (UPSTREAM && slot_power.valid) begin
			splv_r <= slot_power.value;
			spls_r <= slot_power.scale;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			err_en_r <= 4'h0;
			mps_r    <= 3'h0;
		end else if (wr_ctrl) begin
			err_en_r <= hwdata[3:0];
			mps_r    <= clamp_mps(mps_req, mps_cap_r);
		end
	end

	sticky_bit u_aux (
		.ref_clk (ref_clk),
		.por_n   (por_n),
		.wr_en   (wr_ctrl),
		.wr_val  (hwdata[CTRL_AUX_BIT]),
		.q       (aux_q)
	);

	always_ff @(posedge ref_clk or negedge por_n) begin
		if (!por_n) begin
			aux_out_r <= 1'b0;
		end else begin
			aux_out_r <= aux_q;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			err_report_en <= 4'h0;
			max_payload   <= 3'h0;
		end else begin
			err_report_en <= err_en_r;
			max_payload   <= mps_r;
		end
	end

	assign hrdata       = hrdata_r;
	assign aux_power_en = aux_out_r;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	a_mps_clamp: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_ctrl |=> mps_r <= mps_cap_r) else $error("payload not clamped");
	a_mps_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_ctrl && !cap_load.valid && !wr_load |=> mps_r == clamp_mps($past(mps_req), mps_cap_r))
		else $error("payload write wrong");
	a_err_en: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_ctrl |=> ##1 err_report_en == $past(hwdata[3:0], 2)) else $error("enable wrong");
	a_ctrl_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ctrl_word[15:11] == 5'h0 && ctrl_word[9:8] == 2'h0 && !ctrl_word[4])
		else $error("hardwired control bit set");
	a_cap_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cap_word[31:28] == 4'h0 && cap_word[17:16] == 2'h0 && cap_word[14:3] == 12'h0)
		else $error("capability zero field set");
	a_slot_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
		UPSTREAM && slot_power.valid |=> cap_word[25:18] == $past(slot_power.value)
		&& cap_word[27:26] == $past(slot_power.scale)) else $error("slot power not captured");
	a_cap_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cap_load.valid |=> mps_cap_r == $past(cap_load.mps) && rber_r == $past(cap_load.rber))
		else $error("default load lost");
	a_aux_write: assert property (@(posedge ref_clk) disable iff (!por_n)
		wr_ctrl |=> ##1 aux_power_en == $past(hwdata[CTRL_AUX_BIT], 2))
		else $error("aux enable wrong");
	a_read_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
		take && !hwrite && haddr == CTRL_OFFSET |=> hrdata[31:16] == 16'h0000)
		else $error("control upper bits set");
endmodule : pcie_device_cap_ctrl_regs

// File: devcap_pkg.sv
// Purpose: Constants and carrier types for the device capability and control registers
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: Behaviour list below
// Behaviour
// - Payload capability field bits 2:0 resets to code 001b, 256 bytes.
// - Capability bits 4:3 always read 00b, no phantom functions.
// - Capability bit 5 reads zero, no extended tag support.
// - L0s and L1 acceptable latency fields are read-only, reset 000b.
// - Capability bit 15 resets to 1, role-based error reporting present.
// - Upstream port loads bits 25:18 from slot power message; resets 00h.
// - Upstream port loads bits 27:26 from slot power message scale; resets 00b.
// - Payload capability and role-based defaults replaceable by management or memory load.
// - Four writable error reporting enables in control bits 0..3, reset 0.
// - Control bit 4, relaxed ordering enable, always reads 0.
// - Control payload field 7:5 resets 000b; writes above capability clamp to it.
// - Control bits 8 and 9 always read 0 whatever is written.
// - Control bit 10 is a sticky writable auxiliary power enable, reset 0.
// - Control bit 11, no-snoop enable, always reads 0.
// - Control bits 14:12, read request size, hardwired to 000b.
package devcap_pkg;
	localparam logic [7:0]  CAP_OFFSET      = 8'hE4;
	localparam logic [7:0]  CTRL_OFFSET     = 8'hE8;
	localparam logic [7:0]  LOAD_OFFSET     = 8'hF0;
	localparam logic [2:0]  MPS_CAP_RESET   = 3'h1;
	localparam logic        RBER_RESET      = 1'h1;
	localparam int          CAP_MPS_LSB     = 0;
	localparam int          CAP_RBER_BIT    = 15;
	localparam int          CAP_SPLV_LSB    = 18;
	localparam int          CAP_SPLS_LSB    = 26;
	localparam int          CTRL_MPS_LSB    = 5;
	localparam int          CTRL_AUX_BIT    = 10;
	localparam int          LOAD_RBER_BIT   = 3;

	typedef struct packed {
		logic        valid;
		logic [7:0]  value;
		logic [1:0]  scale;
	} slot_power_s;

	typedef struct packed {
		logic        valid;
		logic [2:0]  mps;
		logic        rber;
	} cap_load_s;
endpackage : devcap_pkg

// File: sticky_bit.sv
// Purpose: Sticky control bit kept across functional reset
// Assumes: por_n is the power-on reset, asynchronous, active low
// Notes: Functional reset has no effect here
`timescale 1ns/100ps
module sticky_bit (
	input  wire logic ref_clk,
	input  wire logic por_n,
	input  wire logic wr_en,
	input  wire logic wr_val,
	output logic      q
);
	always_ff @(posedge ref_clk or negedge por_n) begin
		if (!por_n) begin
			q <= 1'b0;
		end else if (wr_en) begin
			q <= wr_val;
		end
	end
endmodule : sticky_bit

// File: ahb_host.sv
// Purpose: AHB-Lite master standing in for host configuration software
// Assumes: Single word transfers, address phase held until hready
// Notes: ok drops low when the two phases together take 100 cycles
`timescale 1ns/100ps
module ahb_host (
	input  wire logic        ref_clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [7:0]       haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	initial begin
		{hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		hsize <= 3'h2;
		do begin @(posedge ref_clk); n++; end while (hready !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge ref_clk); n++; end while (hready !== 1'b1 && n < 100);
		q = hrdata;
		ok = (n < 100);
	endtask : xfer
endmodule : ahb_host

// File: pcie_device_cap_ctrl_regs_test.sv
// Purpose: Register tests for capability and control words
// Assumes: Zero wait slave, UPSTREAM set
// Notes: Outputs are sampled well after the write lands
`timescale 1ns/100ps
module pcie_device_cap_ctrl_regs_test
	import devcap_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        por_n = 1'b0;
	logic        hsel, hwrite, hreadyout, hresp, aux_power_en;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize, max_payload;
	logic [31:0] hwdata, hrdata;
	logic [3:0]  err_report_en;
	slot_power_s slot_power = '0;
	cap_load_s   cap_load = '0;
	int          err_count = 0;
	int          total_checks = 0;
	always #2 ref_clk = ~ref_clk;
	ahb_host i_host (.ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	pcie_device_cap_ctrl_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .por_n(por_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .slot_power(slot_power), .cap_load(cap_load),
		.err_report_en(err_report_en), .max_payload(max_payload), .aux_power_en(aux_power_en));
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		logic ok;
		i_host.xfer(w, a, d, q, ok);
		if (ok !== 1'b1) begin
			err_count++;
			summarize();
		end
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, exp, q);
	endtask : rdc
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		@(posedge ref_clk);
		rdc("cap", CAP_OFFSET, 32'h0000_8001);
		rdc("ctrl", CTRL_OFFSET, 32'h0000_0000);
		rdc("unmapped", 8'h10, 32'h0000_0000);
		$display("test reset done");
		wr(CTRL_OFFSET, 32'hFFFF_FFFF);
		rdc("ctrl", CTRL_OFFSET, 32'h0000_042F);
		chk("outs", 32'h0000_00F3, {24'h0, err_report_en, max_payload, aux_power_en});
		wr(CAP_OFFSET, 32'h0000_0000);
		rdc("cap", CAP_OFFSET, 32'h0000_8001);
		$display("test write done");
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rdc("ctrl", CTRL_OFFSET, 32'h0000_0400);
		chk("outs", 32'h0000_0001, {24'h0, err_report_en, max_payload, aux_power_en});
		$display("test functional reset done");
		slot_power <= '{1'b1, 8'hA5, 2'h3};
		cap_load <= '{1'b1, 3'h2, 1'b0};
		@(posedge ref_clk);
		slot_power <= '0;
		cap_load <= '0;
		@(posedge ref_clk);
		rdc("cap", CAP_OFFSET, 32'h0E94_0002);
		wr(CTRL_OFFSET, 32'h0000_00E0);
		rdc("ctrl", CTRL_OFFSET, 32'h0000_0040);
		wr(LOAD_OFFSET, 32'h0000_000C);
		rdc("cap", CAP_OFFSET, 32'h0E94_8004);
		$display("test load done");
		wr(CTRL_OFFSET, 32'h0000_0440);
		por_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		por_n <= 1'b1;
		@(posedge ref_clk);
		rdc("ctrl", CTRL_OFFSET, 32'h0000_0040);
		$display("test power-on reset done");
		summarize();
	end
endmodule : pcie_device_cap_ctrl_regs_test
